// ---- inc/nes_pkg.sv ----
// Constants, register map and carrier types of the sector error status block.
package nes_pkg;

    // ****************************************************************
    // Register map (byte addresses, one aligned 32-bit word each)
    // ****************************************************************
    localparam logic [6:0] OFS_CTRL = 7'h00;
    localparam logic [6:0] OFS_MODE = 7'h04;
    localparam logic [6:0] OFS_STAT_LO = 7'h08;
    localparam logic [6:0] OFS_PAR0 = 7'h0c;
    localparam logic [6:0] OFS_PAR1 = 7'h10;
    localparam logic [6:0] OFS_STAT_HI = 7'h14;
    localparam logic [6:0] OFS_PAR2 = 7'h18;
    localparam logic [6:0] OFS_PAR15 = 7'h4c;
    localparam logic [6:0] OFS_IRQ_STAT = 7'h50;
    localparam logic [6:0] OFS_IRQ_MASK = 7'h54;
    // Word index of parity register 2 is six, so index minus four gives its number.
    localparam logic [4:0] PAR_IDX_BIAS = 5'h04;

    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam int unsigned NUM_SECTORS = 16;
    localparam int unsigned SECT_PER_WORD = 8;
    localparam int unsigned GROUP_W = 4;
    localparam int unsigned FLD_REC = 0;
    localparam int unsigned FLD_CODE = 1;
    localparam int unsigned FLD_MUL = 2;
    localparam int unsigned CTRL_PAR_CLR_BIT = 0;
    localparam int unsigned CTRL_SOFT_RST_BIT = 1;
    localparam int unsigned MODE_PAGE_LSB = 0;
    localparam int unsigned MODE_CORR_LSB = 4;
    localparam int unsigned IRQ_DONE_BIT = 0;
    localparam int unsigned IRQ_REC_BIT = 1;
    localparam int unsigned IRQ_MUL_BIT = 2;
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned NARROW_LOC_W = 16;
    localparam int unsigned WIDE_LOC_W = 24;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_SECT = 16'h0000;
    localparam logic [2:0] RST_IRQ = 3'h0;
    localparam logic [1:0] RST_PAGE = 2'h0;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0]
    {
        CORR_PAGE = 2'h0,
        CORR_256 = 2'h1,
        CORR_512 = 2'h2,
        CORR_RSVD = 2'h3
    } nes_corr_t;

    typedef enum logic [1:0]
    {
        BUS_IDLE,
        BUS_FETCH,
        BUS_DONE
    } nes_bus_t;

    typedef struct packed
    {
        logic read;
        logic write;
        logic [6:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } nes_avl_req_t;

    typedef struct packed
    {
        logic waitrequest;
        logic [31:0] readdata;
    } nes_avl_rsp_t;

    typedef struct packed
    {
        logic valid;
        logic [11:0] sector_base;
        logic any_err;
        logic code_err;
        logic multi_err;
        logic [31:0] locator;
    } nes_result_t;

    typedef struct packed
    {
        logic [15:0][31:0] mem;
        logic [31:0] q;
    } nes_mem_state_t;

    typedef struct packed
    {
        nes_bus_t bus;
        logic rd_mem;
        logic [31:0] rdata;
        nes_corr_t corr;
        logic [1:0] page;
        logic [15:0] pend_rec;
        logic [15:0] pend_code;
        logic [15:0] pend_mul;
        logic [31:0] stat_lo;
        logic [31:0] stat_hi;
        logic [15:0] par_vld;
        logic [15:0] par1_page;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
    } nes_state_t;

endpackage

// ---- logic/nes_par_mem.sv ----
// Sixteen-word store of error locators with a registered read port.
`timescale 1ns/1ps
module nes_par_mem
(
    input wire logic clk, // system clock
    input wire logic arst_n, // asynchronous reset, active low
    input wire logic we, // write strobe
    input wire logic [3:0] waddr, // write word index
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] raddr, // read word index
    output logic [31:0] rdata // read data, one cycle after raddr
);

    nes_pkg::nes_mem_state_t st_ff;
    nes_pkg::nes_mem_state_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        if (we)
        begin
            nxt_st.mem[waddr] = wdata;
        end
        nxt_st.q = st_ff.mem[raddr];
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign rdata = st_ff.q;

endmodule

// ---- logic/nes_status.sv ----
// Per-sector error status registers with locator store, bus slave and interrupt.
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module nes_status
(
    input wire logic clk, // system clock, 40 MHz
    input wire logic arst_n, // asynchronous reset, active low
    input wire nes_pkg::nes_avl_req_t avl_i, // Avalon-MM request from the master
    output nes_pkg::nes_avl_rsp_t avl_o, // Avalon-MM answer
    input wire nes_pkg::nes_result_t res_i, // per-sector result from the compare logic
    input wire logic page_done, // pulse, page read complete
    input wire logic flash_cmd, // pulse, flash read or write command seen
    output logic irq // level interrupt
);

    // ****************************************************************
    // State
    // ****************************************************************
    nes_pkg::nes_state_t st_ff;
    nes_pkg::nes_state_t nxt_st;

    logic [3:0] sec;
    logic sec_ok;
    logic take;
    logic wr_ctrl;
    logic soft_rst;
    logic par_clr;
    logic clr_all;
    logic [4:0] widx;
    logic [3:0] par_idx;
    logic par_hit;
    logic [31:0] reg_val;
    logic rd_from_mem;
    logic mem_we;
    logic [31:0] mem_wdata;
    logic [31:0] mem_q;
    logic [15:0] new_rec;
    logic [15:0] new_code;
    logic [15:0] new_mul;
    logic [15:0] sect_en;
    logic [1:0][31:0] packed_w;
    logic [2:0] irq_ev;
    logic [2:0] irq_w1c;

    // ****************************************************************
    // Locator store
    // ****************************************************************
    nes_par_mem u_par_mem
    (
        .clk(clk),
        .arst_n(arst_n),
        .we(mem_we),
        .waddr(sec),
        .wdata(mem_wdata),
        .raddr(par_idx),
        .rdata(mem_q)
    );

    // ****************************************************************
    // Sector decode
    // ****************************************************************
    always_comb
    begin
        sec = 4'h0;
        sec_ok = 1'b0;
        unique case (st_ff.corr)
            nes_pkg::CORR_PAGE:
            begin
                sec_ok = 1'b1;
            end
            // 256-byte sectors up to sector 15
            nes_pkg::CORR_256:
            begin
                sec = res_i.sector_base[11:8];
                sec_ok = 1'b1;
            end
            nes_pkg::CORR_512:
            begin
                sec = {1'b0, res_i.sector_base[11:9]};
                sec_ok = 1'b1;
            end
            // The reserved mode has no sector layout, so results are dropped.
            nes_pkg::CORR_RSVD:
            begin
                sec = 4'h0;
                sec_ok = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    always_comb
    begin
        wr_ctrl = avl_i.write && avl_i.byteenable[0] && (avl_i.address == nes_pkg::OFS_CTRL);
        soft_rst = wr_ctrl && avl_i.writedata[nes_pkg::CTRL_SOFT_RST_BIT];
        par_clr = wr_ctrl && avl_i.writedata[nes_pkg::CTRL_PAR_CLR_BIT];
        clr_all = flash_cmd || soft_rst;
        take = res_i.valid && sec_ok && !soft_rst;
        irq_w1c = 3'h0;
        if (avl_i.write && avl_i.byteenable[0] && (avl_i.address == nes_pkg::OFS_IRQ_STAT))
        begin
            irq_w1c = avl_i.writedata[2:0];
        end
        widx = avl_i.address[6:2] - nes_pkg::PAR_IDX_BIAS;
        par_idx = 4'h0;
        par_hit = 1'b0;
        if (avl_i.address == nes_pkg::OFS_PAR0)
        begin
            par_hit = 1'b1;
        end
        else if (avl_i.address == nes_pkg::OFS_PAR1)
        begin
            par_idx = 4'h1;
            par_hit = 1'b1;
        end
        else if ((avl_i.address >= nes_pkg::OFS_PAR2) && (avl_i.address <= nes_pkg::OFS_PAR15)
                 && (avl_i.address[1:0] == 2'h0))
        begin
            par_idx = widx[3:0];
            par_hit = 1'b1;
        end
    end

    // ****************************************************************
    // Register read mux
    // ****************************************************************
    always_comb
    begin
        reg_val = nes_pkg::RST_WORD;
        rd_from_mem = 1'b0;
        if (par_hit)
        begin
            // second half of a whole-page locator
            if ((par_idx == 4'h1) && (st_ff.corr == nes_pkg::CORR_PAGE))
            begin
                reg_val = {16'h0000, st_ff.par1_page & {16{st_ff.par_vld[1]}}};
            end
            else
            begin
                rd_from_mem = st_ff.par_vld[par_idx];
            end
        end
        else
        begin
            unique case (avl_i.address)
                nes_pkg::OFS_MODE:
                begin
                    reg_val[nes_pkg::MODE_PAGE_LSB +: 2] = st_ff.page;
                    reg_val[nes_pkg::MODE_CORR_LSB +: 2] = st_ff.corr;
                end
                nes_pkg::OFS_STAT_LO: reg_val = st_ff.stat_lo;
                nes_pkg::OFS_STAT_HI: reg_val = st_ff.stat_hi;
                nes_pkg::OFS_IRQ_STAT: reg_val[2:0] = st_ff.irq_stat;
                nes_pkg::OFS_IRQ_MASK: reg_val[2:0] = st_ff.irq_mask;
                default: reg_val = nes_pkg::RST_WORD;
            endcase
        end
    end

    // ****************************************************************
    // Flag accumulation and packing
    // ****************************************************************
    always_comb
    begin
        new_rec = clr_all ? nes_pkg::RST_SECT : st_ff.pend_rec;
        new_code = clr_all ? nes_pkg::RST_SECT : st_ff.pend_code;
        new_mul = clr_all ? nes_pkg::RST_SECT : st_ff.pend_mul;
        // A result in a flash_cmd clearing cycle belongs to the new operation, so it is kept; a soft reset cycle drops it.
        if (take)
        begin
            new_rec[sec] = new_rec[sec] | res_i.any_err;
            // error inside the stored code bytes
            new_code[sec] = new_code[sec] | res_i.code_err;
            new_mul[sec] = new_mul[sec] | res_i.multi_err;
        end
        packed_w = '0;
        sect_en = '0;
        for (int n = 0; n < nes_pkg::NUM_SECTORS; n++)
        begin
            // whole-page mode shows sector 0 only
            sect_en[n] = (st_ff.corr != nes_pkg::CORR_PAGE) || (n == 0);
            // low word groups high word groups
            packed_w[n / nes_pkg::SECT_PER_WORD]
                [nes_pkg::GROUP_W * (n % nes_pkg::SECT_PER_WORD) + nes_pkg::FLD_REC] =
                new_rec[n] & sect_en[n];
            packed_w[n / nes_pkg::SECT_PER_WORD]
                [nes_pkg::GROUP_W * (n % nes_pkg::SECT_PER_WORD) + nes_pkg::FLD_CODE] =
                new_code[n] & sect_en[n];
            packed_w[n / nes_pkg::SECT_PER_WORD]
                [nes_pkg::GROUP_W * (n % nes_pkg::SECT_PER_WORD) + nes_pkg::FLD_MUL] =
                new_mul[n] & sect_en[n];
        end
        irq_ev = 3'h0;
        irq_ev[nes_pkg::IRQ_DONE_BIT] = page_done;
        irq_ev[nes_pkg::IRQ_REC_BIT] = page_done && (|(new_rec & sect_en));
        irq_ev[nes_pkg::IRQ_MUL_BIT] = page_done && (|(new_mul & sect_en));
    end

    // ****************************************************************
    // Locator write data
    // ****************************************************************
    always_comb
    begin
        mem_we = take;
        if (st_ff.corr == nes_pkg::CORR_PAGE)
        begin
            // low half into parity word 0
            mem_wdata = {16'h0000, res_i.locator[nes_pkg::NARROW_LOC_W - 1:0]};
        end
        else
        begin
            // sector 0 wide locator sector n into word n
            mem_wdata = {8'h00, res_i.locator[nes_pkg::WIDE_LOC_W - 1:0]};
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.pend_rec = new_rec;
        nxt_st.pend_code = new_code;
        nxt_st.pend_mul = new_mul;
        if (clr_all || par_clr)
        begin
            nxt_st.par_vld = nes_pkg::RST_SECT;
            nxt_st.par1_page = nes_pkg::RST_SECT;
        end
        if (clr_all)
        begin
            nxt_st.stat_lo = nes_pkg::RST_WORD;
            nxt_st.stat_hi = nes_pkg::RST_WORD;
        end
        if (take)
        begin
            nxt_st.par_vld[sec] = 1'b1;
            if (st_ff.corr == nes_pkg::CORR_PAGE)
            begin
                // high half into parity word 1
                nxt_st.par_vld[1] = 1'b1;
                nxt_st.par1_page = res_i.locator[31:16];
            end
        end
        // publish at page completion, clear on flash_cmd or soft reset, hold otherwise
        if (page_done && !soft_rst)
        begin
            nxt_st.stat_lo = packed_w[0];
            nxt_st.stat_hi = packed_w[1];
        end
        // Events win over a write-one-to-clear in the same cycle.
        nxt_st.irq_stat = (st_ff.irq_stat & ~irq_w1c) | irq_ev;
        if (avl_i.write && avl_i.byteenable[0])
        begin
            if (avl_i.address == nes_pkg::OFS_MODE)
            begin
                nxt_st.page = avl_i.writedata[nes_pkg::MODE_PAGE_LSB +: 2];
                nxt_st.corr = nes_pkg::nes_corr_t'(avl_i.writedata[nes_pkg::MODE_CORR_LSB +: 2]);
            end
            if (avl_i.address == nes_pkg::OFS_IRQ_MASK)
            begin
                nxt_st.irq_mask = avl_i.writedata[2:0];
            end
        end
        // soft reset returns every register to its reset value
        if (soft_rst)
        begin
            nxt_st.corr = nes_pkg::CORR_PAGE;
            nxt_st.page = nes_pkg::RST_PAGE;
            nxt_st.irq_stat = nes_pkg::RST_IRQ;
            nxt_st.irq_mask = nes_pkg::RST_IRQ;
        end
        // Reads take two wait cycles because the locator store answers from a register.
        unique case (st_ff.bus)
            nes_pkg::BUS_IDLE:
            begin
                if (avl_i.read)
                begin
                    nxt_st.rdata = reg_val;
                    nxt_st.rd_mem = rd_from_mem;
                    nxt_st.bus = nes_pkg::BUS_FETCH;
                end
            end
            nes_pkg::BUS_FETCH:
            begin
                if (st_ff.rd_mem)
                begin
                    nxt_st.rdata = mem_q;
                end
                nxt_st.bus = nes_pkg::BUS_DONE;
            end
            nes_pkg::BUS_DONE:
            begin
                nxt_st.bus = nes_pkg::BUS_IDLE;
            end
            default:
            begin
                nxt_st.bus = nes_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign avl_o.waitrequest = avl_i.read && (st_ff.bus != nes_pkg::BUS_DONE);
    assign avl_o.readdata = st_ff.rdata;
    assign irq = |(st_ff.irq_stat & st_ff.irq_mask);

endmodule

// ---- sim/nes_status_chk.sv ----
// Port-level assertion checker for the sector error status block.
`timescale 1ns/1ps
module nes_status_chk
(
    input wire logic clk, // system clock
    input wire logic arst_n, // asynchronous reset, active low
    input wire nes_pkg::nes_avl_req_t avl_i, // bus request
    input wire nes_pkg::nes_avl_rsp_t avl_o, // bus answer
    input wire nes_pkg::nes_result_t res_i, // sector result
    input wire logic page_done, // publish pulse
    input wire logic flash_cmd, // clear pulse
    input wire logic irq // level interrupt
);
    // ****************************************************************
    // Helper state
    // ****************************************************************
    logic [1:0] mode_ff;
    logic [1:0] pub_ff;
    logic sclr_ff;
    logic pclr_ff;
    logic done;
    logic st;
    logic par;
    logic wr_ctl;
    logic srst;
    logic mwr;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    assign done = avl_i.read && !avl_o.waitrequest;
    assign st = avl_i.address == nes_pkg::OFS_STAT_LO || avl_i.address == nes_pkg::OFS_STAT_HI;
    assign par = avl_i.address == nes_pkg::OFS_PAR0 || avl_i.address == nes_pkg::OFS_PAR1 ||
        (avl_i.address >= nes_pkg::OFS_PAR2 && avl_i.address <= nes_pkg::OFS_PAR15);
    assign wr_ctl = avl_i.write && avl_i.byteenable[0] && avl_i.address == nes_pkg::OFS_CTRL;
    assign srst = wr_ctl && avl_i.writedata[1];
    assign mwr = avl_i.write && avl_i.address == nes_pkg::OFS_IRQ_MASK;
    // A clear flag stays set until new content may legally appear, so any read meanwhile is zero.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode_ff <= 2'h0;
            pub_ff <= 2'h0;
            sclr_ff <= 1'b1;
            pclr_ff <= 1'b1;
        end
        else
        begin
            if (srst) mode_ff <= 2'h0;
            else if (avl_i.write && avl_i.byteenable[0] && avl_i.address == nes_pkg::OFS_MODE)
                mode_ff <= avl_i.writedata[5:4];
            if (page_done) pub_ff <= mode_ff;
            if (srst) sclr_ff <= 1'b1;
            else if (page_done) sclr_ff <= 1'b0;
            else if (flash_cmd) sclr_ff <= 1'b1;
            if (srst) pclr_ff <= 1'b1;
            else if (res_i.valid) pclr_ff <= 1'b0;
            else if (flash_cmd || (wr_ctl && avl_i.writedata[0])) pclr_ff <= 1'b1;
        end
    end
    // ****************************************************************
    // Properties
    // ****************************************************************
    sequence s_rd_go;
        $rose(avl_i.read);
    endsequence
    sequence s_rd_wait;
        avl_o.waitrequest [*2] ##1 !avl_o.waitrequest;
    endsequence
    property p_rd_lat;
        s_rd_go |-> s_rd_wait;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer not after two waits");
    property p_wr_now;
        avl_i.write |-> !avl_o.waitrequest;
    endproperty
    a_wr_now: assert property (p_wr_now) else $error("write stalled");
    property p_lo_rsvd;
        done && avl_i.address == nes_pkg::OFS_STAT_LO |-> (avl_o.readdata & 32'h88888888) == 32'h0;
    endproperty
    a_lo_rsvd: assert property (p_lo_rsvd) else $error("low status reserved bit set");
    property p_hi_rsvd;
        done && avl_i.address == nes_pkg::OFS_STAT_HI |-> (avl_o.readdata & 32'h88888888) == 32'h0;
    endproperty
    a_hi_rsvd: assert property (p_hi_rsvd) else $error("high status reserved bit set");
    property p_mul_rec;
        done && st |-> ((avl_o.readdata >> 2) & ~avl_o.readdata & 32'h11111111) == 32'h0;
    endproperty
    a_mul_rec: assert property (p_mul_rec) else $error("multiple flag without recoverable");
    property p_page_only;
        done && st && pub_ff == 2'h0 |->
            (avl_o.readdata & ((avl_i.address == nes_pkg::OFS_STAT_LO) ?
            32'hfffffff0 : 32'hffffffff)) == 32'h0;
    endproperty
    a_page_only: assert property (p_page_only) else $error("sector flag set in page mode");
    property p_clr_st;
        done && st && sclr_ff |-> avl_o.readdata == 32'h0;
    endproperty
    a_clr_st: assert property (p_clr_st) else $error("status not cleared");
    property p_clr_par;
        done && par && pclr_ff |-> avl_o.readdata == 32'h0;
    endproperty
    a_clr_par: assert property (p_clr_par) else $error("parity word not cleared");
    property p_irq_rise;
        $rose(irq) |-> $past(page_done) || $past(mwr);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose without cause");
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the sector error status block.
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) \
        begin \
            n_mismatch++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end
module tb_top;
    logic clk;
    logic arst_n;
    nes_pkg::nes_avl_req_t avl_i;
    nes_pkg::nes_avl_rsp_t avl_o;
    nes_pkg::nes_result_t res_i;
    logic page_done;
    logic flash_cmd;
    logic irq;
    logic [31:0] rd;
    int n_mismatch;
    int cmp_count;
    int cyc;
    int k;
    int n;
    bit [31:0] seed;
    bit [31:0] par_m [16];
    bit [15:0] p_rec;
    bit [15:0] p_code;
    bit [15:0] p_mul;
    bit [63:0] st_m;
    bit [1:0] m_mode;
    bit [2:0] m_irq;
    bit [2:0] m_mask;
    bit [1:0] rm [5] = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h1};
    bit [1:0] pm [5] = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h0};
    bit [2:0] mk [5] = '{3'h0, 3'h7, 3'h3, 3'h5, 3'h7};
    nes_status nes_status_i (.clk(clk), .arst_n(arst_n), .avl_i(avl_i), .avl_o(avl_o),
        .res_i(res_i), .page_done(page_done), .flash_cmd(flash_cmd), .irq(irq));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            test_done();
        end
    end
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic bit [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [6:0] paddr(input int i);
        return (i == 0) ? nes_pkg::OFS_PAR0 : (i == 1) ? nes_pkg::OFS_PAR1 : 7'(24 + 4 * (i - 2));
    endfunction
    task automatic bus_wr(input logic [6:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        avl_i.write <= 1'b1;
        avl_i.address <= a;
        avl_i.writedata <= d;
        avl_i.byteenable <= be;
        do @(posedge clk); while (avl_o.waitrequest !== 1'b0);
        avl_i.write <= 1'b0;
    endtask
    task automatic bus_rd(input logic [6:0] a);
        @(posedge clk);
        avl_i.read <= 1'b1;
        avl_i.address <= a;
        do @(posedge clk); while (avl_o.waitrequest !== 1'b0);
        rd = avl_o.readdata;
        avl_i.read <= 1'b0;
    endtask
    // Flags are chosen so that a code byte error is always a single error, as the compare logic would.
    task automatic send(input int idx, input bit [31:0] r);
        nes_pkg::nes_result_t v;
        v.valid = 1'b1;
        v.any_err = r[0];
        v.multi_err = r[0] & r[1];
        v.code_err = r[0] & ~r[1] & r[2];
        v.locator = !v.code_err ? 32'h0 : (m_mode == 2'h0) ? 32'h1 << r[8:4] :
            32'h1 << (r[8:4] % 24);
        v.sector_base = (m_mode == 2'h2) ? 12'(idx * 512) | {3'h0, r[9], 8'h0} : 12'(idx * 256);
        @(posedge clk);
        res_i <= v;
        @(posedge clk);
        res_i.valid <= 1'b0;
        if (m_mode == 2'h3) return;
        p_rec[idx] = v.any_err;
        p_code[idx] = v.code_err;
        p_mul[idx] = v.multi_err;
        if (m_mode == 2'h0)
            {par_m[1], par_m[0]} = {16'h0, v.locator[31:16], 16'h0, v.locator[15:0]};
        else par_m[idx] = v.locator;
    endtask
    task automatic publish();
        @(posedge clk);
        page_done <= 1'b1;
        @(posedge clk);
        page_done <= 1'b0;
        st_m = 64'h0;
        // only sector zero in page mode
        for (int s = 0; s < 16; s++)
            if (s == 0 || m_mode != 2'h0) st_m[4 * s +: 3] = {p_mul[s], p_code[s], p_rec[s]};
        m_irq |= {|(st_m & {16{4'h4}}), |(st_m & {16{4'h1}}), 1'b1};
    endtask
    task automatic flash();
        @(posedge clk);
        flash_cmd <= 1'b1;
        @(posedge clk);
        flash_cmd <= 1'b0;
        {p_rec, p_code, p_mul, st_m} = '0;
        par_m = '{default: 32'h0};
    endtask
    task automatic check_all();
        bus_rd(nes_pkg::OFS_STAT_LO);
        `CHK(rd, st_m[31:0])
        bus_rd(nes_pkg::OFS_STAT_HI);
        `CHK(rd, st_m[63:32])
        for (int i = 0; i < 16; i++)
        begin
            bus_rd(paddr(i));
            `CHK(rd, par_m[i])
        end
        bus_rd(nes_pkg::OFS_MODE);
        `CHK(rd, 32'(m_mode) << 4)
        bus_rd(nes_pkg::OFS_IRQ_MASK);
        `CHK(rd, 32'(m_mask))
        bus_rd(nes_pkg::OFS_IRQ_STAT);
        `CHK(rd, 32'(m_irq))
        `CHK(irq, |(m_irq & m_mask))
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        avl_i = '0;
        res_i = '0;
        page_done = 1'b0;
        flash_cmd = 1'b0;
        arst_n = 1'b0;
        seed = 32'd70667;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        for (k = 0; k < 32; k++)
        begin
            bus_rd(7'(4 * k));
            `CHK(rd, 32'h0)
        end
        $display("test reset done");
        for (k = 0; k < 5; k++)
        begin
            bus_wr(nes_pkg::OFS_IRQ_MASK, 32'(mk[k]), 4'hf);
            m_mask = mk[k];
            bus_wr(nes_pkg::OFS_MODE, 32'(rm[k]) << 4, 4'hf);
            m_mode = rm[k];
            flash();
            check_all();
            for (n = 0; n < ((m_mode == 2'h0) ? 1 : (m_mode == 2'h2) ? 8 : 16); n++)
                send(n, xs());
            // nothing published before the page ends
            check_all();
            if (pm[k] != rm[k])
            begin
                bus_wr(nes_pkg::OFS_MODE, 32'(pm[k]) << 4, 4'hf);
                m_mode = pm[k];
                // Parity word 1 now shows a whole-page half, and none came since the clear.
                if (m_mode == 2'h0) par_m[1] = 32'h0;
            end
            publish();
            check_all();
            send(0, 32'h35);
            check_all();
            bus_wr(nes_pkg::OFS_IRQ_STAT, 32'h7, 4'hf);
            m_irq = 3'h0;
            $display("test pass %0d done", k);
        end
        publish();
        bus_wr(nes_pkg::OFS_CTRL, 32'h1, 4'hf);
        par_m = '{default: 32'h0};
        bus_wr(nes_pkg::OFS_MODE, 32'h10, 4'h0);
        check_all();
        bus_wr(nes_pkg::OFS_CTRL, 32'h2, 4'hf);
        {st_m, m_irq, m_mask, m_mode} = '0;
        check_all();
        $display("test control done");
        test_done();
    end
endmodule
bind nes_status nes_status_chk nes_status_chk_i (.clk(clk), .arst_n(arst_n), .avl_i(avl_i),
    .avl_o(avl_o), .res_i(res_i), .page_done(page_done), .flash_cmd(flash_cmd), .irq(irq));
